/* File: src/dsr_params.svh */
// Purpose: Constants for the digit-serial recorder output block
// Assumes: 200 MHz system clock
// Notes: Offsets are byte addresses on the register bus
// Overview of operation
// (R1) Drive half-character code high for right half, low for left half.
// (R2) Scanner drives a three-bit digit address of the digit shown.
// (R3) Digit select follows the digit address when counter is shown directly.
// (R4) Four data lines carry the shown digit as BCD, counter or plug-in.
// (R5) Decimal point lines are active low; low lights that position.
// (R6) Serial output sends one digit per step, least significant first.
// (R7) Serial sequence locks to the scan and repeats while scanning runs.
// (R8) Data clock comes from half-character code; data changes on its fall. The block also changes data on its rise to send the point code.
// (R9) Start marker is raised just before each new scan cycle.
// (R10) Start marker marks the last, most significant digit, never a point.
// (R11) Decimal point enters the sequence as code 15, all lines high.
// (R12) Point code is sent during the right half of its digit.
// (R13) A positive decimal clock pulse goes with the point code.
// (R14) With no point lit, a point goes right of the lowest digit.
// (R15) Unit levels from the plug-in pass straight to the recorder.
// (R16) Active-low print request is buffered into a positive print command.
// (R17) Hold low inhibits the display cycle end and a new measurement.
// (R18) Reset line is two-way: external reset, own reset drives it.
// (R19) Overflow output goes low while the display overflows.
// (R20) Transfer low passes counter digits to storage; high keeps them. The block clears storage in the reset state even with transfer high.
// (R21) Data and start marker hold steady from one data clock fall to next. The block changes data on the rise that starts the point code.
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH
`define DSR_CLK_PERIOD_NS 5
`define DSR_DISP_TIME_NS 100000
`define DSR_RST_PULSE_NS 1000
`define DSR_DISP_CYCLES ((`DSR_DISP_TIME_NS + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_RST_CYCLES ((`DSR_RST_PULSE_NS + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_NUM_DIGITS 8
`define DSR_DP_CODE 4'hF
`define DSR_DP_MAX 3'h5
`define DSR_OFS_CTRL 4'h0
`define DSR_OFS_DP 4'h4
`define DSR_OFS_STATUS 4'h8
`define DSR_CTRL_RUN 0
`define DSR_CTRL_BYPASS 1
`define DSR_CTRL_RST 2'h1
`define DSR_DP_RST 3'h0
`define DSR_EXT_GUARD 16'h0003
`endif

/* File: src/dsr_pkg.sv */
// Purpose: Types for the digit-serial recorder output block
// Assumes: Used with dsr_params.svh
// Notes: Nothing is imported; users write dsr_pkg::name
package dsr_pkg;

  typedef enum logic [2:0] {
    DSR_ST_MEAS = 3'b001,
    DSR_ST_DISP = 3'b010,
    DSR_ST_RST = 3'b100
  } dsr_state_t;

  typedef struct packed {
    logic data_clk;
    logic start;
    logic dec_clk;
    logic [3:0] data;
  } dsr_ser_t;

  typedef struct packed {
    logic scan_s1;
    logic scan_s2;
    logic scan_d;
    logic hold_s1;
    logic hold_s2;
    logic prn_s1;
    logic prn_s2;
    logic rstl_s1;
    logic rstl_s2;
    logic [4:0] unit_s1;
    logic [4:0] unit_s2;
    logic [3:0] plg_s1;
    logic [3:0] plg_s2;
    logic half;
    logic [2:0] addr;
    logic [7:0][3:0] store;
    logic [3:0] lines;
    dsr_ser_t ser;
    logic ovf;
    logic prn_out;
    dsr_state_t st;
    logic [15:0] tmr;
    logic ack;
    logic [31:0] rdata;
    logic ctrl_run;
    logic ctrl_bypass;
    logic [2:0] dp_sel;
  } dsr_regs_t;

endpackage : dsr_pkg

/* File: src/dsr_recorder_out.sv */
// Purpose: Display scanner and digit-serial recorder output
// Assumes: Scan clock and recorder pins are asynchronous to clk_sys_in
// Notes: Register bus is Avalon-MM; every access answers one cycle late
`timescale 1ns/1ps
`default_nettype none
`include "dsr_params.svh"

module dsr_recorder_out #(
  parameter int NUM_DIGITS = `DSR_NUM_DIGITS,
  parameter int DISP_CYCLES = `DSR_DISP_CYCLES,
  parameter int RST_CYCLES = `DSR_RST_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic scan_clk_in,
  input wire logic [3:0] counter_digit_in,
  input wire logic [3:0] plugin_data_in,
  input wire logic transfer_n_in,
  input wire logic meas_done_in,
  input wire logic overflow_in,
  input wire logic [4:0] unit_n_in,
  input wire logic print_n_in,
  input wire logic hold_n_in,
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe_out,
  output logic half_char_out,
  output logic [2:0] digit_addr_out,
  output logic [2:0] digit_select_out,
  output logic [3:0] data_lines_out,
  output logic decimal_point_one_n_out,
  output logic decimal_point_two_n_out,
  output logic decimal_point_three_n_out,
  output logic decimal_point_four_n_out,
  output logic decimal_point_five_n_out,
  output dsr_pkg::dsr_ser_t ser_out,
  output logic [4:0] unit_n_out,
  output logic print_out,
  output logic overflow_n_out,
  output logic measure_en_out
);

  initial begin
    if (NUM_DIGITS < 6 || NUM_DIGITS > 8) begin
      $error("NUM_DIGITS must be 6 to 8");
    end
    if (DISP_CYCLES < 1 || DISP_CYCLES > 65535) begin
      $error("DISP_CYCLES out of range");
    end
    if (RST_CYCLES < 4 || RST_CYCLES > 65535) begin
      $error("RST_CYCLES out of range");
    end
  end

  localparam logic [2:0] LAST_DIGIT = 3'(NUM_DIGITS - 1);
  localparam logic [15:0] DISP_END = 16'(DISP_CYCLES - 1);
  localparam logic [15:0] RST_END = 16'(RST_CYCLES - 1);

  dsr_pkg::dsr_regs_t r_reg;
  dsr_pkg::dsr_regs_t r_next;
  logic step;
  logic [2:0] addr_inc;
  logic [2:0] dp_idx;
  logic [3:0] digit_val;
  logic ext_rst;
  logic bus_req;

  assign step = r_reg.scan_s2 & ~r_reg.scan_d & r_reg.ctrl_run; // (R7)
  assign addr_inc = (r_reg.addr == LAST_DIGIT) ? 3'h0 : r_reg.addr + 3'h1;
  // Out-of-range selects fall back to the default point position
  assign dp_idx = (r_reg.dp_sel >= 3'h1 && r_reg.dp_sel <= `DSR_DP_MAX) ?
                  r_reg.dp_sel : 3'h0; // (R14)
  assign digit_val = r_reg.ctrl_bypass ? r_reg.plg_s2 : r_reg.store[addr_inc]; // (R4)
  // Own drive echoes back through the synchroniser, so ignore it briefly
  assign ext_rst = r_reg.rstl_s2 && (r_reg.st != dsr_pkg::DSR_ST_RST) &&
                   !(r_reg.st == dsr_pkg::DSR_ST_MEAS && r_reg.tmr < `DSR_EXT_GUARD); // (R18)
  assign bus_req = avs_read_in | avs_write_in;

  always_comb begin
    r_next = r_reg;
    r_next.scan_s1 = scan_clk_in;
    r_next.scan_s2 = r_reg.scan_s1;
    r_next.scan_d = r_reg.scan_s2;
    r_next.hold_s1 = hold_n_in;
    r_next.hold_s2 = r_reg.hold_s1;
    r_next.prn_s1 = print_n_in;
    r_next.prn_s2 = r_reg.prn_s1;
    r_next.rstl_s1 = reset_line_in;
    r_next.rstl_s2 = r_reg.rstl_s1;
    r_next.unit_s1 = unit_n_in;
    r_next.unit_s2 = r_reg.unit_s1; // (R15)
    r_next.plg_s1 = plugin_data_in;
    r_next.plg_s2 = r_reg.plg_s1;
    r_next.ovf = overflow_in; // (R19)
    r_next.prn_out = ~r_reg.prn_s2 & (r_reg.st != dsr_pkg::DSR_ST_RST); // (R16)

    if (step) begin // (R21)
      if (r_reg.half) begin
        r_next.half = 1'b0; // (R1)
        r_next.addr = addr_inc; // (R2)
        r_next.ser.data = digit_val; // (R6)
        r_next.ser.start = (addr_inc == LAST_DIGIT); // (R9)
        r_next.ser.dec_clk = 1'b0;
      end else begin
        r_next.half = 1'b1; // (R1)
        if (r_reg.addr == dp_idx) begin // (R12)
          r_next.ser.data = `DSR_DP_CODE; // (R11)
          r_next.ser.dec_clk = 1'b1; // (R13)
          r_next.ser.start = 1'b0; // (R10)
        end
      end
      r_next.ser.data_clk = ~r_reg.half; // (R8)
    end

    // Direct counter display: digit select equals digit address
    if (!transfer_n_in) begin
      r_next.store[r_reg.addr] = counter_digit_in; // (R20)
    end
    r_next.lines = r_reg.ctrl_bypass ? r_reg.plg_s2 : r_reg.store[r_reg.addr]; // (R4)

    case (r_reg.st)
      dsr_pkg::DSR_ST_MEAS: begin
        if (r_reg.tmr < `DSR_EXT_GUARD) begin
          r_next.tmr = r_reg.tmr + 16'h0001;
        end
        if (meas_done_in) begin
          r_next.st = dsr_pkg::DSR_ST_DISP;
          r_next.tmr = 16'h0000;
        end
      end
      dsr_pkg::DSR_ST_DISP: begin
        if (r_reg.tmr != DISP_END) begin
          r_next.tmr = r_reg.tmr + 16'h0001;
        end else if (r_reg.hold_s2) begin
          r_next.st = dsr_pkg::DSR_ST_RST; // (R17)
          r_next.tmr = 16'h0000;
        end
      end
      dsr_pkg::DSR_ST_RST: begin
        r_next.store = '0;
        if (r_reg.tmr == RST_END) begin
          r_next.st = dsr_pkg::DSR_ST_MEAS;
          r_next.tmr = 16'h0000;
        end else begin
          r_next.tmr = r_reg.tmr + 16'h0001;
        end
      end
      default: begin
        r_next.st = dsr_pkg::DSR_ST_RST;
        r_next.tmr = 16'h0000;
      end
    endcase
    if (ext_rst) begin
      r_next.st = dsr_pkg::DSR_ST_RST; // (R18)
      r_next.tmr = 16'h0000;
    end

    // Bus answers on the second cycle of every access
    r_next.ack = bus_req & ~r_reg.ack;
    if (avs_read_in && !r_reg.ack) begin
      case (avs_address_in)
        `DSR_OFS_CTRL: r_next.rdata = 32'({r_reg.ctrl_bypass, r_reg.ctrl_run});
        `DSR_OFS_DP: r_next.rdata = 32'(r_reg.dp_sel);
        `DSR_OFS_STATUS: r_next.rdata = 32'({r_reg.hold_s2, r_reg.ovf, r_reg.st,
                                             r_reg.addr, r_reg.half});
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_in && r_reg.ack && avs_byteenable_in[0]) begin
      case (avs_address_in)
        `DSR_OFS_CTRL: begin
          r_next.ctrl_run = avs_writedata_in[`DSR_CTRL_RUN];
          r_next.ctrl_bypass = avs_writedata_in[`DSR_CTRL_BYPASS];
        end
        `DSR_OFS_DP: r_next.dp_sel = avs_writedata_in[2:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r_reg <= '0;
      r_reg.hold_s1 <= 1'b1;
      r_reg.hold_s2 <= 1'b1;
      r_reg.prn_s1 <= 1'b1;
      r_reg.prn_s2 <= 1'b1;
      r_reg.unit_s1 <= 5'h1F;
      r_reg.unit_s2 <= 5'h1F;
      r_reg.st <= dsr_pkg::DSR_ST_MEAS;
      r_reg.ctrl_run <= 1'(`DSR_CTRL_RST);
      r_reg.ctrl_bypass <= 1'b0;
      r_reg.dp_sel <= `DSR_DP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_waitrequest_out = bus_req & ~r_reg.ack;
  assign avs_readdata_out = r_reg.rdata;
  assign half_char_out = r_reg.half; // (R1)
  assign digit_addr_out = r_reg.addr; // (R2)
  assign digit_select_out = r_reg.addr; // (R3)
  assign data_lines_out = r_reg.lines;
  assign decimal_point_one_n_out = ~(r_reg.dp_sel == 3'h1); // (R5)
  assign decimal_point_two_n_out = ~(r_reg.dp_sel == 3'h2); // (R5)
  assign decimal_point_three_n_out = ~(r_reg.dp_sel == 3'h3); // (R5)
  assign decimal_point_four_n_out = ~(r_reg.dp_sel == 3'h4); // (R5)
  assign decimal_point_five_n_out = ~(r_reg.dp_sel == 3'h5); // (R5)
  assign ser_out = r_reg.ser;
  assign unit_n_out = r_reg.unit_s2; // (R15)
  assign print_out = r_reg.prn_out; // (R16)
  assign overflow_n_out = ~r_reg.ovf; // (R19)
  assign measure_en_out = (r_reg.st == dsr_pkg::DSR_ST_MEAS); // (R17)
  assign reset_line_oe_out = (r_reg.st == dsr_pkg::DSR_ST_RST); // (R18)
  assign reset_line_out = (r_reg.st == dsr_pkg::DSR_ST_RST); // (R18)

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_right_fall;
    $fell(r_reg.half);
  endsequence

  sequence s_dp_slot;
    $rose(r_reg.half) ##0 (r_reg.addr == dp_idx) ##0 $stable(dp_idx);
  endsequence

  a_half_step: assert property (step |=> r_reg.half != $past(r_reg.half)) // (R1)
    else $error("half code did not toggle on scan edge");

  a_addr_advance: assert property (s_right_fall |->
    r_reg.addr == (($past(r_reg.addr) == LAST_DIGIT) ? 3'h0 : 3'($past(r_reg.addr) + 1))) // (R2)
    else $error("digit address did not advance");

  a_select_follow: assert property (digit_select_out == digit_addr_out) // (R3)
    else $error("digit select differs from address");

  a_dp_line: assert property (r_reg.dp_sel == 3'h2 |-> !decimal_point_two_n_out) // (R5)
    else $error("decimal point line not low");

  a_lsd_first: assert property (s_right_fall ##0 (r_reg.addr == 3'h0) |->
    !ser_out.start && !ser_out.dec_clk) // (R6)
    else $error("lowest digit step carries marker");

  a_data_on_edge: assert property ($changed(ser_out.data) |->
    $changed(ser_out.data_clk)) // (R8)
    else $error("serial data moved without data clock edge");

  a_start_msd: assert property (ser_out.start |->
    r_reg.addr == LAST_DIGIT && !ser_out.dec_clk) // (R10)
    else $error("start marker off the last digit");

  a_point_code: assert property (ser_out.dec_clk |->
    ser_out.data == `DSR_DP_CODE && r_reg.half) // (R11)
    else $error("decimal clock without point code");

  a_point_slot: assert property (s_dp_slot |-> ser_out.dec_clk) // (R12)
    else $error("point code missing in its slot");

  a_point_pulse: assert property ($rose(ser_out.dec_clk) |-> $rose(r_reg.half)) // (R13)
    else $error("decimal clock not on right half start");

  a_print_buf: assert property (!r_reg.prn_s2 && r_reg.st != dsr_pkg::DSR_ST_RST
    |=> print_out) // (R16)
    else $error("print command not raised");

  a_hold_inhibit: assert property (r_reg.st == dsr_pkg::DSR_ST_DISP && !r_reg.hold_s2
    && !ext_rst |=> r_reg.st == dsr_pkg::DSR_ST_DISP) // (R17)
    else $error("display cycle ended under hold");

  a_reset_pulse: assert property ($rose(reset_line_oe_out) |->
    reset_line_oe_out [*4]) // (R18)
    else $error("reset drive too short");

  a_overflow: assert property (overflow_in |=> !overflow_n_out) // (R19)
    else $error("overflow output not low");

  a_store_pass: assert property (!transfer_n_in && r_reg.st != dsr_pkg::DSR_ST_RST
    && !ext_rst |=> r_reg.store[$past(r_reg.addr)] == $past(counter_digit_in)) // (R20)
    else $error("transfer did not load storage");

  a_hold_data: assert property (!$changed(ser_out.data_clk) |-> $stable(ser_out.data)
    && $stable(ser_out.start)) // (R21)
    else $error("serial output moved between clock edges");

  a_run_freeze: assert property (!r_reg.ctrl_run |=> // (R7)
    $stable(r_reg.half) && $stable(r_reg.addr))
    else $error("scan moved while stopped");

  a_start_mark: assert property (s_right_fall |-> // (R9)
    ser_out.start == (r_reg.addr == LAST_DIGIT))
    else $error("start marker wrong on digit step");

  a_bypass_serial: assert property ($fell(r_reg.half) && $past(r_reg.ctrl_bypass) |-> // (R4)
    ser_out.data == $past(r_reg.plg_s2))
    else $error("bypass digit not on serial output");

  a_lines_bypass: assert property (r_reg.ctrl_bypass |=> // (R4)
    data_lines_out == $past(r_reg.plg_s2))
    else $error("data lines not showing plug-in data");

  a_lines_store: assert property (!r_reg.ctrl_bypass |=> // (R4)
    data_lines_out == $past(r_reg.store[r_reg.addr]))
    else $error("data lines not showing stored digit");

  a_default_point: assert property ($rose(ser_out.dec_clk) && $past(r_reg.dp_sel) == 3'h0 |-> // (R14)
    r_reg.addr == 3'h0)
    else $error("default point not at lowest digit");

  a_unit_pass: assert property ($past(rst_b_in) && $past(rst_b_in, 2) |-> // (R15)
    unit_n_out == $past(unit_n_in, 2))
    else $error("unit levels not passed through");

  a_overflow_clear: assert property (!overflow_in |=> // (R19)
    overflow_n_out)
    else $error("overflow output low without overflow");

  a_ext_reset: assert property (ext_rst |=> // (R18)
    r_reg.st == dsr_pkg::DSR_ST_RST)
    else $error("external reset not taken");

  a_print_blocked: assert property (r_reg.st == dsr_pkg::DSR_ST_RST |=> // (R18)
    !print_out)
    else $error("print command during reset");

  a_point_onehot: assert property ($onehot0(~{decimal_point_five_n_out, // (R5)
    decimal_point_four_n_out, decimal_point_three_n_out, decimal_point_two_n_out,
    decimal_point_one_n_out})) else $error("more than one point line low");

  a_half_hold: assert property (!step |=> // (R1)
    $stable(r_reg.half))
    else $error("half code moved without scan edge");

  a_dec_fall: assert property ($fell(r_reg.half) |-> // (R13)
    !ser_out.dec_clk)
    else $error("decimal clock high in left half");

endmodule : dsr_recorder_out
`default_nettype wire

/* File: tb/dsr_recorder_model.sv */
// Purpose: Recorder model on the far side of the serial output
// Assumes: Samples with the system clock
// Notes: Logs each half step when it ends; holds after print
`timescale 1ns/1ps
`default_nettype none
module dsr_recorder_model #(
  parameter int HOLD_CYC = 60
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire dsr_pkg::dsr_ser_t ser_in,
  input wire logic print_in,
  input wire logic hold_en_in,
  input wire logic ext_rst_req_in,
  output logic hold_n_out,
  output logic reset_drive_out
);
  dsr_pkg::dsr_ser_t q[$];
  dsr_pkg::dsr_ser_t last_reg;
  logic print_reg;
  int hold_cnt;
  // Line idles at its pull-down level when not requested
  assign reset_drive_out = ext_rst_req_in;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      last_reg <= '0;
      print_reg <= 1'b0;
      hold_cnt <= 0;
      hold_n_out <= 1'b1;
    end else begin
      last_reg <= ser_in;
      print_reg <= print_in;
      // Value held through a whole half step is what a rising-edge sampler sees
      if (ser_in.data_clk != last_reg.data_clk) q.push_back(last_reg);
      if (print_in && !print_reg && hold_en_in) hold_cnt <= HOLD_CYC;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
      hold_n_out <= (hold_cnt == 0);
    end
  end
endmodule : dsr_recorder_model
`default_nettype wire

/* File: tb/tb_dsr_recorder_out.sv */
// Purpose: Self-checking bench for the recorder output block
// Assumes: Scan clock of 64 ns, unrelated to the 5 ns system clock
// Notes: Short display and reset counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_dsr_recorder_out;
  logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, scan = 1'b0, scan_on = 1'b0;
  logic xfer_n = 1'b0, mdone = 1'b0, ovf = 1'b0, prn_n = 1'b1, hold_en = 1'b0;
  logic ext_rst = 1'b0, wait_r, hold_n, rdrv, rl_out, rl_oe, half, prn, ovf_n, meas_en;
  logic [3:0] adr = 4'h0, cnt_dig = 4'h0, plg = 4'h0, dlines;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [4:0] unit_n = 5'h1f, dp_n, unit_o;
  logic [2:0] daddr, dsel;
  dsr_pkg::dsr_ser_t ser;
  wire rline;
  int bad_count = 0, n_checks = 0, key = 3;
  assign rline = (rl_out & rl_oe) | rdrv;
  always #2.5 clk = ~clk;
  // Scan clock stands still until the scan scenario starts it
  always #32 if (scan_on) scan = ~scan;
  always @(posedge clk) cnt_dig <= 4'((dsel + key) % 10);
  dsr_recorder_out #(.DISP_CYCLES(20), .RST_CYCLES(8)) u_dsr_recorder_out (
    .clk_sys_in(clk), .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r), .scan_clk_in(scan),
    .counter_digit_in(cnt_dig), .plugin_data_in(plg), .transfer_n_in(xfer_n),
    .meas_done_in(mdone), .overflow_in(ovf), .unit_n_in(unit_n), .print_n_in(prn_n),
    .hold_n_in(hold_n), .reset_line_in(rline), .reset_line_out(rl_out),
    .reset_line_oe_out(rl_oe), .half_char_out(half), .digit_addr_out(daddr),
    .digit_select_out(dsel), .data_lines_out(dlines), .decimal_point_one_n_out(dp_n[0]),
    .decimal_point_two_n_out(dp_n[1]), .decimal_point_three_n_out(dp_n[2]),
    .decimal_point_four_n_out(dp_n[3]), .decimal_point_five_n_out(dp_n[4]),
    .ser_out(ser), .unit_n_out(unit_o), .print_out(prn), .overflow_n_out(ovf_n),
    .measure_en_out(meas_en));
  dsr_recorder_model #(.HOLD_CYC(60)) u_dsr_recorder_model (
    .clk_in(clk), .rst_b_in(rst_b), .ser_in(ser), .print_in(prn), .hold_en_in(hold_en),
    .ext_rst_req_in(ext_rst), .hold_n_out(hold_n), .reset_drive_out(rdrv));
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic expire(input string what);
    bad_count++;
    $display("MISMATCH %s expected done seen timeout", what);
    conclude();
  endtask : expire
  task automatic await(ref logic s, input logic v, input int lim, input string what);
    int k;
    for (k = 0; k < lim && s !== v; k++) @(negedge clk);
    if (s !== v) expire(what);
  endtask : await
  // Request held until the edge where waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (wait_r === 1'b0) break;
    end
    if (k == 40) expire("waitrequest");
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic qwait(input int n);
    int k;
    u_dsr_recorder_model.q.delete();
    for (k = 0; k < 4000 && u_dsr_recorder_model.q.size() < n; k++) begin
      @(negedge clk);
      chk("select", daddr, dsel);
      chk("data clock", half, ser.data_clk);
    end
    if (u_dsr_recorder_model.q.size() < n) expire("scan steps");
  endtask : qwait
  task automatic t_regs();
    logic [31:0] r;
    int dp;
    bus(1'b0, 4'h0, 32'h0000_0000, r);
    chk("ctrl reset", 32'h0000_0001, r);
    bus(1'b0, 4'h8, 32'h0000_0000, r);
    chk("state", 32'h0000_0010, r & 32'h0000_0070);
    bus(1'b1, 4'hc, 32'h0000_0005, r);
    bus(1'b0, 4'hc, 32'h0000_0000, r);
    chk("unmapped", 32'h0000_0000, r);
    for (dp = 0; dp < 6; dp++) begin
      bus(1'b1, 4'h4, 32'(dp), r);
      repeat (3) @(negedge clk);
      chk("point lines", (dp == 0) ? 5'h1f : 5'(~(5'h01 << (dp - 1))), dp_n);
    end
    $display("t_regs done");
  endtask : t_regs
  task automatic t_serial();
    int i, d, dp, b;
    logic [31:0] r;
    dsr_pkg::dsr_ser_t lf, rt;
    @(posedge clk);
    scan_on <= 1'b1;
    qwait(20);
    @(posedge clk);
    xfer_n <= 1'b1;
    key <= 7;
    for (dp = 0; dp < 6; dp++) begin
      bus(1'b1, 4'h4, 32'(dp), r);
      qwait(36);
      b = -1;
      for (i = 0; i < 18; i++) begin
        lf = u_dsr_recorder_model.q[i];
        if (b < 0 && !lf.data_clk && lf.start) b = i;
      end
      if (b < 0) expire("start marker");
      for (d = 0; d < 8; d++) begin
        lf = u_dsr_recorder_model.q[b + 2 + 2 * d];
        rt = u_dsr_recorder_model.q[b + 3 + 2 * d];
        chk("digit", 32'((d + 3) % 10), lf.data);
        chk("start", 32'(d == 7), lf.start);
        chk("right half", (d == dp || (dp == 0 && d == 0)) ? 15 : (d + 3) % 10, rt.data);
        chk("point clock", 32'(d == dp || (dp == 0 && d == 0)), rt.dec_clk);
      end
    end
    await(half, 1'b1, 40, "right half");
    chk("stored lines", 32'((daddr + 3) % 10), dlines);
    $display("t_serial done");
  endtask : t_serial
  task automatic t_levels();
    logic [31:0] r;
    dsr_pkg::dsr_ser_t e;
    @(posedge clk);
    unit_n <= 5'h15;
    ovf <= 1'b1;
    plg <= 4'h9;
    bus(1'b1, 4'h0, 32'h0000_0003, r);
    repeat (6) @(negedge clk);
    chk("units", 32'h0000_0015, unit_o);
    chk("overflow", 32'h0000_0000, ovf_n);
    chk("bypass data", 32'h0000_0009, dlines);
    qwait(4);
    e = u_dsr_recorder_model.q[1].data_clk ? u_dsr_recorder_model.q[2] : u_dsr_recorder_model.q[1];
    chk("bypass serial", 32'h0000_0009, e.data);
    bus(1'b1, 4'h0, 32'h0000_0000, r);
    repeat (2) @(negedge clk);
    u_dsr_recorder_model.q.delete();
    repeat (60) @(negedge clk);
    chk("frozen steps", 32'h0000_0000, u_dsr_recorder_model.q.size());
    @(posedge clk);
    unit_n <= 5'h0a;
    ovf <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_0001, r);
    repeat (6) @(negedge clk);
    chk("units", 32'h0000_000a, unit_o);
    chk("overflow", 32'h0000_0001, ovf_n);
    $display("t_levels done");
  endtask : t_levels
  task automatic t_cycle();
    @(posedge clk);
    hold_en <= 1'b1;
    prn_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk("print", 32'h0000_0001, prn);
    @(posedge clk);
    hold_en <= 1'b0;
    mdone <= 1'b1;
    @(posedge clk);
    mdone <= 1'b0;
    repeat (4) @(negedge clk);
    chk("measuring", 32'h0000_0000, meas_en);
    await(rl_oe, 1'b1, 300, "reset state");
    @(negedge clk);
    chk("hold honoured", 32'h0000_0001, hold_n);
    chk("reset line", 32'h0000_0001, rline);
    chk("print off", 32'h0000_0000, prn);
    await(meas_en, 1'b1, 100, "measure again");
    @(posedge clk);
    prn_n <= 1'b1;
    $display("t_cycle done");
  endtask : t_cycle
  task automatic t_extrst();
    @(posedge clk);
    ext_rst <= 1'b1;
    await(rl_oe, 1'b1, 50, "external reset");
    @(posedge clk);
    ext_rst <= 1'b0;
    await(meas_en, 1'b1, 100, "reset release");
    repeat (10) @(negedge clk);
    chk("back to measure", 32'h0000_0001, meas_en);
    $display("t_extrst done");
  endtask : t_extrst
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_serial();
    t_levels();
    t_cycle();
    t_extrst();
    conclude();
  end
endmodule : tb_dsr_recorder_out
`default_nettype wire
